// ### verilog/tcp_pkg.sv
// Shared constants and carrier types of the two-channel modulator
package tcp_pkg;
    localparam int          DW          = 8;
    localparam int          AW          = 16;
    localparam logic [15:0] BASE_BLK    = 16'h0200;
    localparam logic [15:0] BASE_NBLK   = 16'h0300;
    localparam logic [7:0]  OFF_CTL     = 8'h60;
    localparam logic [7:0]  OFF_PRCLK   = 8'h61;
    localparam logic [7:0]  OFF_SCLA    = 8'h62;
    localparam logic [7:0]  OFF_SCLB    = 8'h63;
    localparam logic [7:0]  OFF_CNT0    = 8'h64;
    localparam logic [7:0]  OFF_CNT1    = 8'h65;
    localparam logic [7:0]  OFF_PER0    = 8'h66;
    localparam logic [7:0]  OFF_PER1    = 8'h67;
    localparam logic [7:0]  OFF_DTY0    = 8'h68;
    localparam logic [7:0]  OFF_DTY1    = 8'h69;
    localparam logic [7:0]  PRCLK_MASK  = 8'h77;
    localparam int          PRCLK_A_LSB = 0;
    localparam int          PRCLK_B_LSB = 4;
    localparam logic [7:0]  RST_CTL     = 8'h00;
    localparam logic [7:0]  RST_PRCLK   = 8'h00;
    localparam logic [7:0]  RST_SCL     = 8'h00;
    localparam logic [7:0]  RST_PER     = 8'h00;
    localparam logic [7:0]  RST_DTY     = 8'h00;
    localparam int          PRE_W       = 7;

    typedef enum logic {TCP_UP, TCP_DOWN} tcp_dir_e;

    typedef struct packed {
        logic [1:0] center_align_select;
        logic [1:0] clk_sel;
        logic [1:0] output_polarity_select;
        logic [1:0] channel_enable;
    } tcp_ctl_s;

    typedef struct packed {
        logic          wr;
        logic          rd;
        logic [AW-1:0] addr;
        logic [DW-1:0] wdata;
    } tcp_req_s;

    typedef struct packed {
        logic          en;
        logic          center;
        logic          pol;
        logic [DW-1:0] per;
        logic [DW-1:0] dty;
    } tcp_chcfg_s;
endpackage : tcp_pkg

// ### verilog/tcp_prescaler.sv
// Prescaler and scalers producing clock A and B and their scaled enable ticks
`timescale 1ns/1ps
module tcp_prescaler (
    input  wire logic                       sys_clk,
    input  wire logic                       sys_rst,
    input  wire logic                       clk_en,
    input  wire logic                       run,
    input  wire logic [1:0][2:0]            sel,
    input  wire logic [1:0][7:0]            scl,
    input  wire logic [1:0]                 scl_wr,
    output logic      [1:0]                 tick,
    output logic      [1:0]                 stick,
    output logic      [tcp_pkg::PRE_W-1:0]  pre_cnt
);
    import tcp_pkg::*;

    logic [PRE_W-1:0] pre_q;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) pre_q <= '0;
        else if (clk_en) pre_q <= run ? pre_q + 7'h01 : 7'h00;
    end
    assign pre_cnt = pre_q;

    for (genvar g = 0; g < 2; g++) begin : g_src
        logic [PRE_W-1:0] mask;
        logic [8:0]       scl_eff;
        logic [9:0]       lim;
        logic [9:0]       sc_q;
        assign mask    = ~(7'h7f << sel[g]);
        assign tick[g] = run & ((pre_q & mask) == mask);
        assign scl_eff = {scl[g] == 8'h00, scl[g]};
        assign lim      = {scl_eff, 1'b0} - 10'h001;
        assign stick[g] = tick[g] & (sc_q == lim);
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) sc_q <= '0;
            else if (clk_en) begin
                if (scl_wr[g]) sc_q <= '0;
                else if (tick[g]) sc_q <= (sc_q == lim) ? 10'h000 : sc_q + 10'h001;
            end
        end
    end
endmodule : tcp_prescaler

// ### verilog/tcp_channel.sv
// One modulator channel: counter, active period/duty copies, waveform
`timescale 1ns/1ps
module tcp_channel (
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   clk_en,
    input  wire tcp_pkg::tcp_chcfg_s    cfg,
    input  wire logic                   tick,
    input  wire logic                   cnt_clr,
    output logic [tcp_pkg::DW-1:0]      cnt,
    output logic                        run,
    output logic                        wave
);
    import tcp_pkg::*;

    logic [DW-1:0] cnt_q, per_q, dty_q;
    tcp_dir_e      dir_q;
    logic          run_q, wave_q;
    logic          left_end, up_end, down_end;

    assign left_end = ({1'b0, cnt_q} + 9'h001) >= {1'b0, per_q};
    assign up_end   = cnt_q >= per_q;
    assign down_end = cnt_q <= 8'h01;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            cnt_q  <= '0;
            per_q  <= RST_PER;
            dty_q  <= RST_DTY;
            dir_q  <= TCP_UP;
            run_q  <= 1'b0;
            wave_q <= 1'b0;
        end else if (clk_en) begin
            if (cnt_clr) begin
                cnt_q <= '0;
                dir_q <= TCP_UP;
            end else if (!cfg.en) begin
                per_q <= cfg.per;
                dty_q <= cfg.dty;
                dir_q <= TCP_UP;
            end else if (tick && run_q) begin
                if (!cfg.center) begin
                    cnt_q <= left_end ? 8'h00 : cnt_q + 8'h01;
                    if (left_end) begin
                        per_q <= cfg.per;
                        dty_q <= cfg.dty;
                    end
                end else begin
                    case (dir_q)
                        TCP_UP: begin
                            if (per_q == 8'h00) cnt_q <= 8'h00;
                            else if (up_end) begin
                                cnt_q <= cnt_q - 8'h01;
                                dir_q <= TCP_DOWN;
                            end else cnt_q <= cnt_q + 8'h01;
                        end
                        TCP_DOWN: begin
                            if (down_end) begin
                                cnt_q <= 8'h00;
                                dir_q <= TCP_UP;
                                per_q <= cfg.per;
                                dty_q <= cfg.dty;
                            end else cnt_q <= cnt_q - 8'h01;
                        end
                        default: dir_q <= TCP_UP;
                    endcase
                end
            end
            run_q  <= cfg.en & (run_q | tick);
            wave_q <= cfg.en & run_q & ((cnt_q < dty_q) ? cfg.pol : ~cfg.pol);
        end
    end

    assign cnt  = cnt_q;
    assign run  = run_q;
    assign wave = wave_q;
endmodule : tcp_channel

// ### verilog/tcp_pwm_top.sv
// Register file and top level of the two-channel pulse-width modulator
`timescale 1ns/1ps
module tcp_pwm_top (
    input  wire logic                   sys_clk,
    input  wire logic                   sys_rst,
    input  wire logic                   clk_en,
    input  wire tcp_pkg::tcp_req_s      reg_req,
    output logic [tcp_pkg::DW-1:0]      reg_rdata,
    output logic                        reg_ack,
    output logic                        channel0_waveform,
    output logic                        channel1_waveform
);
    import tcp_pkg::*;

    if (DW != 8) begin : g_chk
        $error("tcp_pwm_top supports 8-bit registers only");
    end

    tcp_ctl_s      ctl_q;
    logic [DW-1:0] prclk_q;
    logic [1:0][DW-1:0] scl_q, per_q, dty_q;
    logic [DW-1:0] rdata_q;
    logic          ack_q;

    logic          win_hit, blk_hit, nblk_hit;
    logic [7:0]    off;
    logic          wr_hit, rd_hit, map_hit;
    logic          wr_ctl, wr_prclk;
    logic [1:0]    wr_scl, wr_cnt, wr_per, wr_dty;
    logic [DW-1:0] rd_mux;

    logic [1:0][2:0]    pre_sel;
    logic [1:0]         tick_ab, tick_s, ch_tick, ch_run, ch_wave;
    logic [1:0][DW-1:0] ch_cnt;
    logic [PRE_W-1:0]   pre_cnt;
    tcp_chcfg_s [1:0]   ch_cfg;

    assign blk_hit  = reg_req.addr[15:8] == BASE_BLK[15:8];
    assign nblk_hit = reg_req.addr[15:8] == BASE_NBLK[15:8];
    assign off      = reg_req.addr[7:0];
    assign map_hit  = (off >= OFF_CTL) && (off <= OFF_DTY1);
    assign win_hit  = (blk_hit || nblk_hit) && map_hit;
    assign wr_hit   = win_hit && reg_req.wr;
    assign rd_hit   = win_hit && reg_req.rd;

    assign wr_ctl    = wr_hit && (off == OFF_CTL);
    assign wr_prclk  = wr_hit && (off == OFF_PRCLK);
    assign wr_scl[0] = wr_hit && (off == OFF_SCLA);
    assign wr_scl[1] = wr_hit && (off == OFF_SCLB);
    assign wr_cnt[0] = wr_hit && (off == OFF_CNT0);
    assign wr_cnt[1] = wr_hit && (off == OFF_CNT1);
    assign wr_per[0] = wr_hit && (off == OFF_PER0);
    assign wr_per[1] = wr_hit && (off == OFF_PER1);
    assign wr_dty[0] = wr_hit && (off == OFF_DTY0);
    assign wr_dty[1] = wr_hit && (off == OFF_DTY1);

    // Counter reads come straight from the live count, no side effect
    assign rd_mux = (off == OFF_CTL)   ? DW'(ctl_q) :
                    (off == OFF_PRCLK) ? prclk_q    :
                    (off == OFF_SCLA)  ? scl_q[0]   :
                    (off == OFF_SCLB)  ? scl_q[1]   :
                    (off == OFF_CNT0)  ? ch_cnt[0]  :
                    (off == OFF_CNT1)  ? ch_cnt[1]  :
                    (off == OFF_PER0)  ? per_q[0]   :
                    (off == OFF_PER1)  ? per_q[1]   :
                    (off == OFF_DTY0)  ? dty_q[0]   :
                    (off == OFF_DTY1)  ? dty_q[1]   : 8'h00;

    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            ctl_q   <= RST_CTL;
            prclk_q <= RST_PRCLK;
        end else if (clk_en) begin
            if (wr_ctl) ctl_q <= reg_req.wdata;
            if (wr_prclk) prclk_q <= reg_req.wdata & PRCLK_MASK;
        end
    end

    for (genvar c = 0; c < 2; c++) begin : g_regs
        always_ff @(posedge sys_clk or posedge sys_rst) begin
            if (sys_rst) begin
                scl_q[c] <= RST_SCL;
                per_q[c] <= RST_PER;
                dty_q[c] <= RST_DTY;
            end else if (clk_en) begin
                if (wr_scl[c]) scl_q[c] <= reg_req.wdata;
                if (wr_per[c]) per_q[c] <= reg_req.wdata;
                if (wr_dty[c]) dty_q[c] <= reg_req.wdata;
            end
        end
    end

    // Unmapped reads get no ack and leave rdata unchanged; ack covers writes too
    always_ff @(posedge sys_clk or posedge sys_rst) begin
        if (sys_rst) begin
            rdata_q <= '0;
            ack_q   <= 1'b0;
        end else if (clk_en) begin
            ack_q <= wr_hit || rd_hit;
            if (rd_hit) rdata_q <= rd_mux;
        end
    end
    assign reg_rdata = rdata_q;
    assign reg_ack   = ack_q;

    assign pre_sel[0] = prclk_q[PRCLK_A_LSB +: 3];
    assign pre_sel[1] = prclk_q[PRCLK_B_LSB +: 3];

    tcp_prescaler u_pre (
        .sys_clk (sys_clk),
        .sys_rst (sys_rst),
        .clk_en  (clk_en),
        .run     (|ctl_q.channel_enable),
        .sel     (pre_sel),
        .scl     (scl_q),
        .scl_wr  (wr_scl & {2{clk_en}}),
        .tick    (tick_ab),
        .stick   (tick_s),
        .pre_cnt (pre_cnt)
    );

    for (genvar c = 0; c < 2; c++) begin : g_ch
        assign ch_tick[c] = ctl_q.clk_sel[c] ? tick_s[c] : tick_ab[c];
        assign ch_cfg[c] = '{en:     ctl_q.channel_enable[c],
                             center: ctl_q.center_align_select[c],
                             pol:    ctl_q.output_polarity_select[c],
                             per:    per_q[c],
                             dty:    dty_q[c]};
        tcp_channel u_ch (
            .sys_clk (sys_clk),
            .sys_rst (sys_rst),
            .clk_en  (clk_en),
            .cfg     (ch_cfg[c]),
            .tick    (ch_tick[c]),
            .cnt_clr (wr_cnt[c]),
            .cnt     (ch_cnt[c]),
            .run     (ch_run[c]),
            .wave    (ch_wave[c])
        );
    end

    // The first cycle after enable may be short; software must allow it
    assign channel0_waveform = ch_wave[0];
    assign channel1_waveform = ch_wave[1];

    default clocking @(posedge sys_clk); endclocking
    default disable iff (sys_rst);

    property p_resv_zero;
        prclk_q[7] == 1'b0 && prclk_q[3] == 1'b0;
    endproperty
    a_resv_zero: assert property (p_resv_zero)
        else $error("reserved prescale bits not zero");

    property p_rd_ctl;
        (clk_en && rd_hit && off == OFF_CTL) |=> reg_rdata == DW'($past(ctl_q)) && reg_ack;
    endproperty
    a_rd_ctl: assert property (p_rd_ctl)
        else $error("control read mismatch");

    property p_nb_write;
        (clk_en && reg_req.wr && reg_req.addr == (BASE_NBLK | 16'(OFF_CTL)))
            |=> DW'(ctl_q) == $past(reg_req.wdata);
    endproperty
    a_nb_write: assert property (p_nb_write)
        else $error("non-blocking window write lost");

    property p_unmapped;
        (reg_req.wr && !win_hit) |=> $stable(ctl_q) && $stable(prclk_q);
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped write changed a register");

    property p_dis_out;
        (clk_en && !ctl_q.channel_enable[0]) |=> !channel0_waveform && !ch_run[0];
    endproperty
    a_dis_out: assert property (p_dis_out)
        else $error("disabled channel drives output");

    property p_en_wait;
        (clk_en && ctl_q.channel_enable[0] && !ch_run[0] && !ch_tick[0])
            |=> !ch_run[0] && !channel0_waveform ##1 !channel0_waveform;
    endproperty
    a_en_wait: assert property (p_en_wait)
        else $error("channel started before its clock tick");

    property p_en_start;
        (clk_en && ctl_q.channel_enable[1] && ch_tick[1]) |=> ch_run[1];
    endproperty
    a_en_start: assert property (p_en_start)
        else $error("channel missed its start tick");

    property p_pre_stop;
        (clk_en && ctl_q.channel_enable == 2'b00) |=> pre_cnt == '0;
    endproperty
    a_pre_stop: assert property (p_pre_stop)
        else $error("prescaler runs with both channels off");

    property p_tick_div1;
        (|ctl_q.channel_enable && pre_sel[0] == 3'h0) |-> tick_ab[0];
    endproperty
    a_tick_div1: assert property (p_tick_div1)
        else $error("clock A missing tick at divide by one");

    property p_tick_div2;
        (|ctl_q.channel_enable && pre_sel[1] == 3'h1 && tick_ab[1] && clk_en)
            |=> !tick_ab[1];
    endproperty
    a_tick_div2: assert property (p_tick_div2)
        else $error("clock B ticks too often at divide by two");

    property p_cnt_clr;
        (clk_en && wr_cnt[0]) |=> ch_cnt[0] == 8'h00;
    endproperty
    a_cnt_clr: assert property (p_cnt_clr)
        else $error("counter write did not clear");

    property p_cnt_rd;
        (clk_en && rd_hit && off == OFF_CNT1) |=> reg_rdata == $past(ch_cnt[1]);
    endproperty
    a_cnt_rd: assert property (p_cnt_rd)
        else $error("counter read mismatch");

    // A count left over from a disabled spell may exceed a new period; only the wrap is checked
    property p_left_max;
        (clk_en && ctl_q.channel_enable[0] && ch_run[0] && !ctl_q.center_align_select[0]
            && ch_tick[0] && !wr_cnt[0]
            && ({1'b0, ch_cnt[0]} + 9'h001) >= {1'b0, g_ch[0].u_ch.per_q})
            |=> ch_cnt[0] == 8'h00;
    endproperty
    a_left_max: assert property (p_left_max)
        else $error("left counter passed period");

    property p_pol_lo;
        (clk_en && ctl_q.channel_enable[0] && ch_run[0] && ch_cnt[0] < g_ch[0].u_ch.dty_q)
            |=> channel0_waveform == $past(ctl_q.output_polarity_select[0]);
    endproperty
    a_pol_lo: assert property (p_pol_lo)
        else $error("channel 0 level before duty count wrong");

    property p_pol_hi;
        (clk_en && ctl_q.channel_enable[1] && ch_run[1] && ch_cnt[1] >= g_ch[1].u_ch.dty_q)
            |=> channel1_waveform != $past(ctl_q.output_polarity_select[1]);
    endproperty
    a_pol_hi: assert property (p_pol_hi)
        else $error("channel 1 level after duty count wrong");

    property p_dis_out1;
        (clk_en && !ctl_q.channel_enable[1]) |=> !channel1_waveform && !ch_run[1];
    endproperty
    a_dis_out1: assert property (p_dis_out1)
        else $error("disabled channel 1 drives output");

    property p_dis_load;
        (clk_en && !ctl_q.channel_enable[0] && !wr_cnt[0])
            |=> g_ch[0].u_ch.per_q == $past(per_q[0]) && g_ch[0].u_ch.dty_q == $past(dty_q[0]);
    endproperty
    a_dis_load: assert property (p_dis_load)
        else $error("disabled channel did not take new period and duty");

    property p_scl_restart;
        (clk_en && wr_scl[0]) |=> u_pre.g_src[0].sc_q == 10'h000;
    endproperty
    a_scl_restart: assert property (p_scl_restart)
        else $error("scale write did not restart the scale counter");

    property p_center_turn;
        (clk_en && ctl_q.channel_enable[1] && ch_run[1] && ctl_q.center_align_select[1]
            && ch_tick[1] && !wr_cnt[1] && g_ch[1].u_ch.dir_q == TCP_UP
            && g_ch[1].u_ch.per_q != 8'h00 && ch_cnt[1] >= g_ch[1].u_ch.per_q)
            |=> g_ch[1].u_ch.dir_q == TCP_DOWN;
    endproperty
    a_center_turn: assert property (p_center_turn)
        else $error("center counter did not turn at period");

    property p_ack_idle;
        (clk_en && !reg_req.wr && !reg_req.rd) |=> !reg_ack;
    endproperty
    a_ack_idle: assert property (p_ack_idle)
        else $error("acknowledge without a request");

    c_left_run:   cover property (ch_run[0] && !ctl_q.center_align_select[0] && channel0_waveform);
    c_center_run: cover property (ch_run[1] && ctl_q.center_align_select[1] && channel1_waveform);
    c_scaled:     cover property (ctl_q.clk_sel[0] && ch_tick[0] && ch_run[0]);
    c_cnt_clear:  cover property (clk_en && wr_cnt[1] && ch_run[1]);
    c_nblk_wr:    cover property (clk_en && wr_hit && nblk_hit);
endmodule : tcp_pwm_top

// ### verification/tcp_host_model.sv
// Host-side model of the register master on the die link
`timescale 1ns/1ps
module tcp_host_model (
    input  wire logic                sys_clk,
    output tcp_pkg::tcp_req_s        reg_req,
    input  wire logic [7:0]          reg_rdata,
    input  wire logic                reg_ack
);
    import tcp_pkg::*;

    initial reg_req = '0;

    task automatic access(input logic wr, input logic rd, input logic [AW-1:0] addr,
                          input logic [DW-1:0] wd, output logic [DW-1:0] rdat,
                          output logic ok);
        int gap;
        gap = $urandom_range(2);
        repeat (gap) @(posedge sys_clk);
        @(posedge sys_clk);
        reg_req <= '{wr: wr, rd: rd, addr: addr, wdata: wd};
        @(posedge sys_clk);
        // Released lines show a changed value, not the last one
        reg_req <= '{wr: 1'b0, rd: 1'b0, addr: ~addr, wdata: ~wd};
        ok = 1'b0;
        rdat = 'x;
        for (int i = 0; i < 4 && !ok; i++) begin
            @(posedge sys_clk);
            if (reg_ack === 1'b1) begin
                ok = 1'b1;
                rdat = reg_rdata;
            end
        end
    endtask : access
endmodule : tcp_host_model

// ### verification/testbench.sv
// Self-checking bench for the two-channel modulator
`timescale 1ns/1ps
module testbench;
    import tcp_pkg::*;

    logic          sys_clk;
    logic          sys_rst;
    logic          clk_en;
    tcp_req_s      reg_req;
    logic [DW-1:0] reg_rdata;
    logic          reg_ack;
    logic          channel0_waveform;
    logic          channel1_waveform;
    logic [DW-1:0] rdv;
    logic          ok;
    int            n_errors;
    int            n_checks;
    int            cyc = 0;

    tcp_pwm_top tcp_pwm_top_inst (
        .sys_clk           (sys_clk),
        .sys_rst           (sys_rst),
        .clk_en            (clk_en),
        .reg_req           (reg_req),
        .reg_rdata         (reg_rdata),
        .reg_ack           (reg_ack),
        .channel0_waveform (channel0_waveform),
        .channel1_waveform (channel1_waveform)
    );

    tcp_host_model tcp_host_model_inst (
        .sys_clk   (sys_clk),
        .reg_req   (reg_req),
        .reg_rdata (reg_rdata),
        .reg_ack   (reg_ack)
    );

    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end

    task automatic stop_test();
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : stop_test

    // Long enough for every scenario several times over
    always @(posedge sys_clk) begin
        cyc <= cyc + 1;
        if (cyc == 40000) begin
            n_errors++;
            stop_test();
        end
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            n_errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    function automatic logic [AW-1:0] ga(input logic [7:0] off);
        return ($urandom_range(1) ? BASE_NBLK : BASE_BLK) | AW'(off);
    endfunction : ga

    function automatic logic [7:0] exp_rd(input logic [7:0] off, input logic [7:0] d);
        if (off == OFF_CNT0 || off == OFF_CNT1) begin
            return 8'h00;
        end
        return (off == OFF_PRCLK) ? (d & PRCLK_MASK) : d;
    endfunction : exp_rd

    function automatic logic wv(input int ch);
        return ch ? channel1_waveform : channel0_waveform;
    endfunction : wv

    task automatic wr(input logic [7:0] off, input logic [7:0] d);
        tcp_host_model_inst.access(1'b1, 1'b0, ga(off), d, rdv, ok);
        chk(ok, 1'b1);
    endtask : wr

    task automatic rd(input logic [7:0] off, input logic [7:0] exp);
        tcp_host_model_inst.access(1'b0, 1'b1, ga(off), 8'h00, rdv, ok);
        chk({ok, rdv}, {1'b1, exp});
    endtask : rd

    // first cycle after enable is skipped
    task automatic measure(input int ch, input int ehi, input int eper);
        int hi;
        int per;
        int t;
        t = 0;
        repeat (2) begin
            while (wv(ch) !== 1'b0 && t < 5000) begin
                @(posedge sys_clk);
                t++;
            end
            while (wv(ch) !== 1'b1 && t < 5000) begin
                @(posedge sys_clk);
                t++;
            end
        end
        hi = 0;
        per = 0;
        while (wv(ch) === 1'b1 && per < 5000) begin
            @(posedge sys_clk);
            hi++;
            per++;
        end
        while (wv(ch) === 1'b0 && per < 5000) begin
            @(posedge sys_clk);
            per++;
        end
        if (ehi > 0) chk(16'(hi), 16'(ehi));
        chk(16'(per), 16'(eper));
    endtask : measure

    // Disable first so the new period and duty load at once
    task automatic run_case(input int ch, input logic [7:0] prc, scl, ctl, per, dty,
                            input int ehi, input int eper);
        wr(OFF_CTL, 8'h00);
        wr(OFF_PRCLK, prc);
        wr(ch ? OFF_SCLB : OFF_SCLA, scl);
        wr(ch ? OFF_PER1 : OFF_PER0, per);
        wr(ch ? OFF_DTY1 : OFF_DTY0, dty);
        wr(OFF_CTL, ctl);
        measure(ch, ehi, eper);
    endtask : run_case

    initial begin
        logic [7:0] off;
        logic [7:0] d;
        logic [7:0] a;
        int         p;
        int         q;
        sys_rst = 1'b1;
        clk_en = 1'b1;
        n_errors = 0;
        n_checks = 0;
        void'($urandom(32'h417e36ed));
        repeat (5) @(posedge sys_clk);
        sys_rst <= 1'b0;
        for (int i = 0; i < 10; i++) begin
            rd(8'(OFF_CTL + i), 8'h00);
        end
        for (int i = 0; i < 16; i++) begin
            off = 8'(OFF_PRCLK + $urandom_range(8));
            d = 8'($urandom);
            wr(off, d);
            rd(off, exp_rd(off, d));
        end
        wr(OFF_CTL, 8'hf0);
        rd(OFF_CTL, 8'hf0);
        tcp_host_model_inst.access(1'b1, 1'b0, 16'h0250, 8'h55, rdv, ok);
        chk(ok, 1'b0);
        tcp_host_model_inst.access(1'b0, 1'b1, 16'h0460, 8'h00, rdv, ok);
        chk(ok, 1'b0);
        tcp_host_model_inst.access(1'b0, 1'b1, 16'h036a, 8'h00, rdv, ok);
        chk(ok, 1'b0);
        wr(OFF_CTL, 8'h00);
        wr(OFF_PRCLK, 8'h07);
        wr(OFF_PER0, 8'hc8);
        wr(OFF_DTY0, 8'h64);
        wr(OFF_CTL, 8'h05);
        // output waits for the slow source tick
        repeat (100) begin
            @(posedge sys_clk);
            chk(channel0_waveform, 1'b0);
        end
        repeat (400) @(posedge sys_clk);
        tcp_host_model_inst.access(1'b0, 1'b1, ga(OFF_CNT0), 8'h00, rdv, ok);
        a = rdv;
        chk(a != 8'h00, 1'b1);
        tcp_host_model_inst.access(1'b0, 1'b1, ga(OFF_CNT0), 8'h00, rdv, ok);
        chk(8'(rdv - a) <= 8'h01, 1'b1);
        wr(OFF_CNT0, 8'($urandom));
        tcp_host_model_inst.access(1'b0, 1'b1, ga(OFF_CNT0), 8'h00, rdv, ok);
        chk(rdv <= 8'h01, 1'b1);
        run_case(0, 8'h00, 8'h01, 8'h05, 8'h04, 8'h02, 2, 4);
        run_case(0, 8'h00, 8'h01, 8'h01, 8'h05, 8'h02, 3, 5);
        run_case(0, 8'h03, 8'h01, 8'h05, 8'h04, 8'h01, 8, 32);
        run_case(0, 8'h01, 8'h03, 8'h15, 8'h03, 8'h01, 12, 36);
        run_case(0, 8'h00, 8'h01, 8'h45, 8'h04, 8'h01, 1, 8);
        run_case(1, 8'h20, 8'h01, 8'h0a, 8'h03, 8'h02, 8, 12);
        run_case(1, 8'h00, 8'h02, 8'h2a, 8'h02, 8'h01, 4, 8);
        run_case(1, 8'h00, 8'h01, 8'h8a, 8'h03, 8'h01, 1, 6);
        for (int i = 0; i < 4; i++) begin
            p = $urandom_range(20, 2);
            q = $urandom_range(p - 1, 1);
            run_case(0, 8'h00, 8'h01, 8'h05, 8'(p), 8'(q), q, p);
        end
        wr(OFF_PER0, 8'h06);
        wr(OFF_DTY0, 8'h03);
        measure(0, 3, 6);
        // Clock enable low must freeze the running waveform
        clk_en <= 1'b0;
        @(posedge sys_clk);
        a = {7'h00, channel0_waveform};
        repeat (20) begin
            @(posedge sys_clk);
            chk(channel0_waveform, a[0]);
        end
        clk_en <= 1'b1;
        measure(0, 3, 6);
        stop_test();
    end
endmodule : testbench
